//--- rtl/cirf_top.sv
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - readra low: operand a from entry a
// - writerc stores result into entry c
// - three 5-bit indexes pick entries
// - readrb low: operand a times datab into acc
// - readrb high: acc feeds multiplier; readable
// - extra ports reach top as external
// - external path pushes operand a to fifo
// - result driven with done, same clock
// - clk_en qualifies edges except the XWAIT exit; reset synchronous
// - external interface only on multi-cycle
module cirf_top (
  input wire logic aclk,
  input wire logic aresetn,
  // custom instruction port from the core alu
  input wire logic clk_en,
  input wire logic reset,
  input wire logic start,
  output logic done,
  input wire logic [cirf_pkg::CIRF_NW-1:0] n,
  input wire logic [cirf_pkg::CIRF_DW-1:0] dataa,
  input wire logic [cirf_pkg::CIRF_DW-1:0] datab,
  output logic [cirf_pkg::CIRF_DW-1:0] result,
  input wire logic readra,
  input wire logic readrb,
  input wire logic writerc,
  input wire logic [cirf_pkg::CIRF_IW-1:0] a,
  input wire logic [cirf_pkg::CIRF_IW-1:0] b,
  input wire logic [cirf_pkg::CIRF_IW-1:0] c,
  // external interface toward a fifo outside the core
  output logic ext_valid,
  input wire logic ext_ready,
  output logic [cirf_pkg::CIRF_DW-1:0] ext_data,
  // axi4-lite slave
  input wire logic [cirf_pkg::CIRF_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cirf_pkg::CIRF_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cirf_pkg::CIRF_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cirf_pkg::CIRF_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cirf_pkg::*;

  // ***************************************************************
  // state of the block
  // ***************************************************************
  typedef struct packed {
    cirf_state_t st; // sequencer state
    logic [CIRF_DW-1:0] acc; // multiply-accumulate register
    logic [CIRF_DW-1:0] res; // result shown to the core
    logic done; // done flag shown to the core
    logic xv; // external word valid
    logic [CIRF_DW-1:0] xd; // external word
    logic [7:0] ctrl; // stored control bits
    logic [CIRF_DW-1:0] count; // completed instructions
    logic awv; // write address held
    logic [CIRF_AW-1:0] awaddr; // held write address
    logic wv; // write data held
    logic [CIRF_DW-1:0] wdata; // held write data
    logic [3:0] wstrb; // held write strobes
    logic bv; // write response pending
    logic [1:0] bresp; // write response code
    logic rv; // read response pending
    logic [CIRF_DW-1:0] rdata; // read response data
    logic [1:0] rresp; // read response code
  } cirf_regs_t;

  cirf_regs_t r_r;
  cirf_regs_t r_nxt;

  // register file wiring
  logic [CIRF_DW-1:0] rf_a; // entry a, registered read
  logic [CIRF_DW-1:0] rf_b; // entry b, registered read
  logic rf_we; // register file write strobe
  logic [CIRF_DW-1:0] rf_wd; // register file write data

  // operand and result paths
  logic [CIRF_DW-1:0] opa; // selected operand a
  logic [CIRF_DW-1:0] opb; // selected operand b
  logic [CIRF_DW-1:0] mul_b; // second multiplier input
  logic [2*CIRF_DW-1:0] prod; // full product
  logic [CIRF_DW-1:0] res_v; // result of this operation
  logic go_ext; // this instruction waits on the external path
  logic x_take; // external word taken this edge
  logic wr_fire; // axi write performed this cycle
  logic [CIRF_DW-1:0] rd_v; // axi read decode

  // ***************************************************************
  // internal register file
  // ***************************************************************
  // read ports follow a and b every edge; the core keeps them
  // stable from start on, so the entries are ready one edge later
  cirf_mem u_mem (
    .aclk(aclk),
    .we(rf_we),
    .waddr(c),
    .wdata(rf_wd),
    .raddr_a(a),
    .raddr_b(b),
    .rdata_a(rf_a),
    .rdata_b(rf_b)
  );

  // ***************************************************************
  // operand selection and arithmetic
  // ***************************************************************
  // flags and indexes are not latched: they stand until done
  always_comb begin
    // core word or internal entry, per flag
    opa = readra ? dataa : rf_a;
    opb = readrb ? datab : rf_b;
    // mac: readrb high loops the accumulator back in
    mul_b = readrb ? r_r.acc : datab;
    prod = {CIRF_ZERO, opa} * {CIRF_ZERO, mul_b};
    go_ext = (n == CIRF_OP_EXT) && r_r.ctrl[CIRF_CTRL_EXT_EN];
    unique case (n)
      CIRF_OP_MAC: res_v = prod[CIRF_DW-1:0];
      CIRF_OP_MOV: res_v = opa;
      CIRF_OP_ACC: res_v = r_r.acc;
      CIRF_OP_EXT: res_v = opb;
    endcase
  end

  // external handshake is plain valid/ready on aclk; the fifo
  // outside knows nothing of clk_en, so it is not qualified
  assign x_take = r_r.xv && ext_ready;

  // ***************************************************************
  // register file write strobe
  // ***************************************************************
  always_comb begin
    rf_wd = r_nxt.res;
    rf_we = 1'b0;
    if (!(reset && clk_en) && aresetn && writerc) begin
      // write lands in entry c together with done rising
      if (((r_r.st == CIRF_S_EXEC) && clk_en && !go_ext) ||
          ((r_r.st == CIRF_S_XWAIT) && x_take)) begin
        rf_we = 1'b1;
      end
    end
  end

  // ***************************************************************
  // axi read decode
  // ***************************************************************
  always_comb begin
    rd_v = CIRF_ZERO;
    unique case (s_axi_araddr)
      CIRF_OFS_CTRL: rd_v = {24'h00_0000, r_r.ctrl};
      CIRF_OFS_STATUS: begin
        rd_v[CIRF_STAT_BUSY] = (r_r.st != CIRF_S_IDLE);
        rd_v[CIRF_STAT_EXT] = r_r.xv;
      end
      CIRF_OFS_ACC: rd_v = r_r.acc;
      CIRF_OFS_COUNT: rd_v = r_r.count;
      default: rd_v = CIRF_ZERO;
    endcase
  end

  assign wr_fire = r_r.awv && r_r.wv && !r_r.bv;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    r_nxt = r_r;

    // axi write address and data channels, either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_nxt.awv = 1'b1;
      r_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_nxt.wv = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    // response retires before a new one may be set
    if (r_r.bv && s_axi_bready) begin
      r_nxt.bv = 1'b0;
    end
    if (wr_fire) begin
      r_nxt.awv = 1'b0;
      r_nxt.wv = 1'b0;
      r_nxt.bv = 1'b1;
      r_nxt.bresp = CIRF_RESP_OKAY;
      unique case (r_r.awaddr)
        CIRF_OFS_CTRL: begin
          if (r_r.wstrb[0]) begin
            r_nxt.ctrl = r_r.wdata[7:0] & CIRF_CTRL_MASK;
            // clear only between instructions; mac update wins
            if (r_r.wdata[CIRF_CTRL_ACC_CLR] &&
                (r_r.st == CIRF_S_IDLE)) begin
              r_nxt.acc = CIRF_ZERO;
            end
          end
        end
        // status, acc and count take writes without effect
        CIRF_OFS_STATUS, CIRF_OFS_ACC, CIRF_OFS_COUNT: begin
          r_nxt.bresp = CIRF_RESP_OKAY;
        end
        default: r_nxt.bresp = CIRF_RESP_SLVERR;
      endcase
    end

    // axi read channel
    if (r_r.rv && s_axi_rready) begin
      r_nxt.rv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_nxt.rv = 1'b1;
      r_nxt.rdata = rd_v;
      r_nxt.rresp = CIRF_RESP_OKAY;
      unique case (s_axi_araddr)
        CIRF_OFS_CTRL, CIRF_OFS_STATUS,
        CIRF_OFS_ACC, CIRF_OFS_COUNT: r_nxt.rresp = CIRF_RESP_OKAY;
        default: r_nxt.rresp = CIRF_RESP_SLVERR;
      endcase
    end

    // external word leaves on its own handshake
    if (x_take) begin
      r_nxt.xv = 1'b0;
    end

    // instruction sequencer, every step but the XWAIT exit qualified by clk_en
    unique case (r_r.st)
      CIRF_S_IDLE: begin
        // start counts only on a qualified edge
        if (clk_en && start) begin
          r_nxt.st = CIRF_S_EXEC;
        end
      end
      CIRF_S_EXEC: begin
        if (clk_en) begin
          if (n == CIRF_OP_MAC) begin
            r_nxt.acc = prod[CIRF_DW-1:0];
          end
          if (go_ext) begin
            // only this multi-cycle sequencer reaches the port
            r_nxt.xv = 1'b1;
            r_nxt.xd = opa;
            r_nxt.st = CIRF_S_XWAIT;
          end else begin
            r_nxt.res = res_v;
            r_nxt.done = 1'b1;
            r_nxt.st = CIRF_S_DONE;
          end
        end
      end
      CIRF_S_XWAIT: begin
        // back-pressure from the fifo stretches the instruction
        // result waits for done so the core never sees it early
        if (x_take) begin
          r_nxt.res = res_v;
          r_nxt.done = 1'b1;
          r_nxt.st = CIRF_S_DONE;
        end
      end
      CIRF_S_DONE: begin
        // done and result stand until the core samples them
        if (clk_en) begin
          r_nxt.done = 1'b0;
          r_nxt.count = r_r.count + CIRF_ONE;
          r_nxt.st = CIRF_S_IDLE;
        end
      end
      default: r_nxt.st = CIRF_S_IDLE;
    endcase

    // core reset only when clk_en qualifies the edge
    if (reset && clk_en) begin
      r_nxt.st = CIRF_S_IDLE;
      r_nxt.done = 1'b0;
      r_nxt.acc = CIRF_ZERO;
      r_nxt.res = CIRF_ZERO;
      r_nxt.xv = 1'b0;
    end
  end

  // ***************************************************************
  // state register, synchronous active-low system reset
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r.st <= CIRF_S_IDLE;
      r_r.acc <= CIRF_ZERO;
      r_r.res <= CIRF_ZERO;
      r_r.done <= 1'b0;
      r_r.xv <= 1'b0;
      r_r.xd <= CIRF_ZERO;
      r_r.ctrl <= CIRF_CTRL_RST;
      r_r.count <= CIRF_ZERO;
      r_r.awv <= 1'b0;
      r_r.awaddr <= '0;
      r_r.wv <= 1'b0;
      r_r.wdata <= CIRF_ZERO;
      r_r.wstrb <= 4'h0;
      r_r.bv <= 1'b0;
      r_r.bresp <= CIRF_RESP_OKAY;
      r_r.rv <= 1'b0;
      r_r.rdata <= CIRF_ZERO;
      r_r.rresp <= CIRF_RESP_OKAY;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign done = r_r.done;
  assign result = r_r.res;
  assign ext_valid = r_r.xv;
  assign ext_data = r_r.xd;
  assign s_axi_awready = !r_r.awv && !r_r.bv;
  assign s_axi_wready = !r_r.wv && !r_r.bv;
  assign s_axi_bvalid = r_r.bv;
  assign s_axi_bresp = r_r.bresp;
  assign s_axi_arready = !r_r.rv;
  assign s_axi_rvalid = r_r.rv;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;

endmodule : cirf_top

//--- rtl/cirf_pkg.sv
// ***************************************************************
// custom instruction register file block: shared constants
// ***************************************************************
package cirf_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int unsigned CIRF_DW = 32; // operand and result width
  localparam int unsigned CIRF_IW = 5; // register file index width
  localparam int unsigned CIRF_DEPTH = 32; // one entry per index value
  localparam int unsigned CIRF_NW = 2; // operation select width
  localparam int unsigned CIRF_AW = 4; // axi byte address width used

  // ***************************************************************
  // axi4-lite register map (byte addresses)
  // ***************************************************************
  localparam logic [CIRF_AW-1:0] CIRF_OFS_CTRL = 4'h0; // control
  localparam logic [CIRF_AW-1:0] CIRF_OFS_STATUS = 4'h4; // status
  localparam logic [CIRF_AW-1:0] CIRF_OFS_ACC = 4'h8; // accumulator
  localparam logic [CIRF_AW-1:0] CIRF_OFS_COUNT = 4'hc; // done count

  // control fields
  localparam int unsigned CIRF_CTRL_EXT_EN = 0; // enable external push
  localparam int unsigned CIRF_CTRL_ACC_CLR = 1; // clear acc, self clearing
  localparam logic [7:0] CIRF_CTRL_RST = 8'h01; // ext path on by default
  localparam logic [7:0] CIRF_CTRL_MASK = 8'h01; // stored control bits

  // status fields
  localparam int unsigned CIRF_STAT_BUSY = 0; // instruction under way
  localparam int unsigned CIRF_STAT_EXT = 1; // external word pending

  // axi responses
  localparam logic [1:0] CIRF_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIRF_RESP_SLVERR = 2'h2;

  // reset value of data state and the count step
  localparam logic [CIRF_DW-1:0] CIRF_ZERO = 32'h0000_0000;
  localparam logic [CIRF_DW-1:0] CIRF_ONE = 32'h0000_0001;

  // ***************************************************************
  // operations selected by the n input
  // ***************************************************************
  localparam logic [CIRF_NW-1:0] CIRF_OP_MAC = 2'h0; // multiply into acc
  localparam logic [CIRF_NW-1:0] CIRF_OP_MOV = 2'h1; // pass operand a
  localparam logic [CIRF_NW-1:0] CIRF_OP_ACC = 2'h2; // read accumulator
  localparam logic [CIRF_NW-1:0] CIRF_OP_EXT = 2'h3; // push to external

  // ***************************************************************
  // sequencer states, one-hot
  // ***************************************************************
  typedef enum logic [3:0] {
    CIRF_S_IDLE = 4'b0001, // waiting for start
    CIRF_S_EXEC = 4'b0010, // operands ready, compute
    CIRF_S_XWAIT = 4'b0100, // waiting for external ready
    CIRF_S_DONE = 4'b1000 // done shown until a qualified edge
  } cirf_state_t;

endpackage : cirf_pkg

//--- rtl/cirf_mem.sv
`timescale 1ns/1ps
// ***************************************************************
// internal register file: one write port, two registered reads
// ***************************************************************
module cirf_mem (
  input wire logic aclk,
  input wire logic we,
  input wire logic [cirf_pkg::CIRF_IW-1:0] waddr,
  input wire logic [cirf_pkg::CIRF_DW-1:0] wdata,
  input wire logic [cirf_pkg::CIRF_IW-1:0] raddr_a,
  input wire logic [cirf_pkg::CIRF_IW-1:0] raddr_b,
  output logic [cirf_pkg::CIRF_DW-1:0] rdata_a,
  output logic [cirf_pkg::CIRF_DW-1:0] rdata_b
);
  import cirf_pkg::*;

  // read data registers kept as one struct
  typedef struct packed {
    logic [CIRF_DW-1:0] rd_a; // read data, port a
    logic [CIRF_DW-1:0] rd_b; // read data, port b
  } cirf_mem_t;

  cirf_mem_t r;
  cirf_mem_t nxt;
  // storage has no reset: contents are defined only once written
  logic [CIRF_DW-1:0] mem [CIRF_DEPTH];

  // ***************************************************************
  // read path
  // ***************************************************************
  // old data on a same-cycle write: reads never see the new word
  always_comb begin
    nxt = r;
    nxt.rd_a = mem[raddr_a];
    nxt.rd_b = mem[raddr_b];
  end

  always_ff @(posedge aclk) begin
    r <= nxt;
  end

  // ***************************************************************
  // write path, one generate entry per index
  // ***************************************************************
  for (genvar i = 0; i < CIRF_DEPTH; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (we && (waddr == CIRF_IW'(i))) begin
        mem[i] <= wdata;
      end
    end
  end

  assign rdata_a = r.rd_a;
  assign rdata_b = r.rd_b;

endmodule : cirf_mem

//--- testbench/cirf_props.sv
`timescale 1ns/1ps
// ****
// port checker for the custom instruction block
// ****
module cirf_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic reset,
  input wire logic done,
  input wire logic [cirf_pkg::CIRF_DW-1:0] result,
  input wire logic ext_valid,
  input wire logic ext_ready,
  input wire logic [cirf_pkg::CIRF_DW-1:0] ext_data,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cirf_pkg::CIRF_DW-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cirf_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // done lasts only to the next qualified edge
  done_drop_a:
    assert property (done && clk_en |=> !done)
    else $error("done outlived a qualified edge");
  gate_hold_a:
    assert property (done && !clk_en |=> done && $stable(result))
    else $error("state moved on an unqualified edge");
  // result only moves when done rises, or on core reset
  res_cause_a:
    assert property (!$past(reset) && $changed(result) |-> $rose(done))
    else $error("result moved without done");
  ext_hold_a:
    assert property (ext_valid && !ext_ready && !(reset && clk_en)
      |=> ext_valid && $stable(ext_data))
    else $error("external word dropped before ready");
  ext_done_a:
    assert property (ext_valid && ext_ready |=> done && !ext_valid)
    else $error("external push did not complete");
  done_cause_a:
    assert property ($rose(done) |-> $past(clk_en) || $past(ext_ready))
    else $error("done rose on an unqualified edge");
  core_rst_a:
    assert property (reset && clk_en |=> !done && !ext_valid
      && result == CIRF_ZERO)
    else $error("core reset did not clear");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
endmodule : cirf_props

bind cirf_top cirf_props cirf_props_inst (.*);

//--- testbench/cirf_fifo_model.sv
`timescale 1ns/1ps
// ****
// external fifo sink, stalls a set number of cycles
// ****
module cirf_fifo_model (
  input wire logic aclk,
  input wire logic ext_valid,
  input wire logic [cirf_pkg::CIRF_DW-1:0] ext_data,
  input wire logic [7:0] stall,
  output logic ext_ready,
  output logic [cirf_pkg::CIRF_DW-1:0] got,
  output logic [7:0] nwords
);
  import cirf_pkg::*;
  logic [7:0] wait_c; // cycles waited on this word
  initial begin
    ext_ready = 1'b0;
    got = CIRF_ZERO;
    nwords = 8'h00;
    wait_c = 8'h00;
  end
  // ready is a one-cycle pulse, never held idle high
  always @(posedge aclk) begin
    ext_ready <= 1'b0;
    if (ext_valid && ext_ready) begin
      got <= ext_data;
      nwords <= nwords + 8'h01;
      wait_c <= 8'h00;
    end else if (ext_valid) begin
      if (wait_c >= stall) ext_ready <= 1'b1;
      else wait_c <= wait_c + 8'h01;
    end
  end
endmodule : cirf_fifo_model

//--- testbench/cirf_top_tb.sv
`timescale 1ns/1ps
module cirf_top_tb;
  import cirf_pkg::*;
  // ****
  // signals
  // ****
  logic aclk, aresetn, clk_en, reset, start, done;
  logic readra, readrb, writerc, ext_valid, ext_ready;
  logic [CIRF_NW-1:0] n;
  logic [CIRF_DW-1:0] dataa, datab, result, ext_data, got, r;
  logic [CIRF_IW-1:0] a, b, c;
  logic [7:0] stall, nwords, w0;
  logic [CIRF_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [CIRF_DW-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int failures, tests_run, cyc, ecnt;

  cirf_top cirf_top_inst (.*);
  cirf_fifo_model cirf_fifo_model_inst (.aclk(aclk),
    .ext_valid(ext_valid), .ext_data(ext_data), .stall(stall),
    .ext_ready(ext_ready), .got(got), .nwords(nwords));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  task tally_and_finish();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ready is registered, so the falling edge shows what the next rise takes
  task automatic axi_wr(logic [3:0] ad, logic [31:0] d);
    logic fa, fw, fb;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge aclk);
      fa = s_axi_awvalid && s_axi_awready;
      fw = s_axi_wvalid && s_axi_wready;
      fb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (fa) s_axi_awvalid <= 1'b0;
      if (fw) s_axi_wvalid <= 1'b0;
      if (fb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    chk("write answer", 32'h1, {31'h0, fb});
  endtask : axi_wr
  task automatic axi_rd(logic [3:0] ad, output logic [31:0] d);
    logic fa, fr;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge aclk);
      fa = s_axi_arvalid && s_axi_arready;
      fr = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (fa) s_axi_arvalid <= 1'b0;
      if (fr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    chk("read answer", 32'h1, {31'h0, fr});
  endtask : axi_rd
  // one instruction: flags stay put until done, then one edge to drop it
  task automatic ci(logic [1:0] op, logic ra, rb, wc, logic [4:0] ia, ic,
                    logic [31:0] da, db);
    @(posedge aclk);
    n <= op;
    readra <= ra;
    readrb <= rb;
    writerc <= wc;
    a <= ia;
    b <= ia;
    c <= ic; // flags and indexes stand until the next call
    dataa <= da;
    datab <= db;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    r = 'x;
    for (int k = 0; k < 100; k++) begin
      @(posedge aclk);
      #1;
      if (done === 1'b1) begin
        if (wc) r = result;
        break;
      end
    end
    chk("done seen", 32'h1, {31'h0, done});
    @(posedge aclk);
    ecnt++;
  endtask : ci
  // ****
  // scenarios
  // ****
  task s_axi();
    axi_rd(CIRF_OFS_CTRL, r);
    chk("ctrl reset", {24'h0, CIRF_CTRL_RST}, r);
    axi_wr(CIRF_OFS_STATUS, 32'hffff_ffff);
    chk("ro write resp", {30'h0, CIRF_RESP_OKAY}, {30'h0, rsp});
    axi_rd(CIRF_OFS_STATUS, r);
    chk("status idle", CIRF_ZERO, r);
    axi_rd(4'h2, r);
    chk("unmapped resp", {30'h0, CIRF_RESP_SLVERR}, {30'h0, rsp});
  endtask : s_axi
  task s_mac();
    ci(CIRF_OP_MAC, 1'b1, 1'b0, 1'b1, 5'h00, 5'h05, 32'h3, 32'h4);
    chk("mac result", 32'hc, r);
    axi_rd(CIRF_OFS_ACC, r);
    chk("acc readback", 32'hc, r);
    ci(CIRF_OP_MAC, 1'b1, 1'b1, 1'b1, 5'h00, 5'h00, 32'h5, 32'h9);
    chk("acc feedback", 32'h3c, r);
  endtask : s_mac
  // done must stand through edges with the qualifier low
  task s_hold();
    @(posedge aclk);
    n <= CIRF_OP_ACC;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
    clk_en <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk("done held", 32'h1, {31'h0, done});
    chk("acc result", 32'h3c, result);
    @(posedge aclk);
    clk_en <= 1'b1;
    @(posedge aclk);
    #1;
    chk("done dropped", 32'h0, {31'h0, done});
    ecnt++;
  endtask : s_hold
  task s_rf();
    ci(CIRF_OP_MOV, 1'b0, 1'b1, 1'b1, 5'h05, 5'h1f, 32'h0, 32'h0);
    chk("entry 5", 32'hc, r);
    ci(CIRF_OP_MOV, 1'b0, 1'b1, 1'b1, 5'h1f, 5'h1e, 32'h0, 32'h0);
    chk("entry 31", 32'hc, r);
    ci(CIRF_OP_MOV, 1'b1, 1'b1, 1'b0, 5'h00, 5'h05, 32'h77, 32'h0);
    ci(CIRF_OP_MOV, 1'b0, 1'b1, 1'b1, 5'h05, 5'h1e, 32'h0, 32'h0);
    chk("no write", 32'hc, r);
  endtask : s_rf
  task s_ext();
    w0 = nwords;
    ci(CIRF_OP_EXT, 1'b1, 1'b0, 1'b1, 5'h05, 5'h1e, 32'hcafe_0123, 32'h0);
    chk("entry b", 32'hc, r);
    chk("ext word", 32'hcafe_0123, got);
    chk("ext count", {24'h0, w0 + 8'h01}, {24'h0, nwords});
    axi_wr(CIRF_OFS_CTRL, CIRF_ZERO);
    ci(CIRF_OP_EXT, 1'b1, 1'b1, 1'b0, 5'h00, 5'h00, 32'h5555, 32'h0);
    chk("ext off", {24'h0, w0 + 8'h01}, {24'h0, nwords});
    axi_wr(CIRF_OFS_CTRL, CIRF_ONE);
  endtask : s_ext
  task s_gate();
    @(posedge aclk);
    clk_en <= 1'b0;
    start <= 1'b1;
    n <= CIRF_OP_MOV;
    repeat (6) @(posedge aclk);
    #1;
    chk("gated done", 32'h0, {31'h0, done});
    @(posedge aclk);
    start <= 1'b0;
    clk_en <= 1'b1;
    axi_rd(CIRF_OFS_STATUS, r);
    chk("gated busy", CIRF_ZERO, r);
  endtask : s_gate
  task s_rst();
    // core reset on an unqualified edge must be ignored
    @(posedge aclk);
    clk_en <= 1'b0;
    reset <= 1'b1;
    @(posedge aclk);
    clk_en <= 1'b1;
    reset <= 1'b0;
    axi_rd(CIRF_OFS_ACC, r);
    chk("gated reset", 32'h3c, r);
    @(posedge aclk);
    reset <= 1'b1;
    @(posedge aclk);
    reset <= 1'b0;
    ci(CIRF_OP_ACC, 1'b1, 1'b1, 1'b1, 5'h00, 5'h1e, 32'h0, 32'h0);
    chk("acc cleared", CIRF_ZERO, r);
    axi_rd(CIRF_OFS_COUNT, r);
    chk("done count", ecnt, r);
    // software clear of the accumulator while idle
    ci(CIRF_OP_MAC, 1'b1, 1'b0, 1'b1, 5'h00, 5'h1e, 32'h2, 32'h3);
    chk("mac after reset", 32'h6, r);
    axi_wr(CIRF_OFS_CTRL, 32'h0000_0003);
    axi_rd(CIRF_OFS_ACC, r);
    chk("acc clear", CIRF_ZERO, r);
  endtask : s_rst
  // ****
  // main sequence
  // ****
  initial begin
    {aresetn, clk_en, reset, start, readra, readrb, writerc} = '0;
    {n, dataa, datab, a, b, c, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    stall = 8'h03;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    clk_en <= 1'b1;
    s_axi();
    s_mac();
    s_hold();
    s_rf();
    s_ext();
    s_gate();
    s_rst();
    tally_and_finish();
  end
endmodule : cirf_top_tb
